// ===== include/pxs_pkg.sv
`default_nettype none
package pxs_pkg;
   // ------------------------------------------------------------
   // register addresses (5-bit management register numbers)
   // ------------------------------------------------------------
   localparam logic [4:0] PXS_ADDR_PAGE = 5'h08;
   localparam logic [4:0] PXS_ADDR_PRE = 5'h14;
   localparam logic [4:0] PXS_ADDR_CNT = 5'h15;
   localparam logic [4:0] PXS_ADDR_IRQ = 5'h1B;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int PXS_PAGE_NP = 15;
   localparam int PXS_PAGE_ACK = 14;
   localparam int PXS_PAGE_MP = 13;
   localparam int PXS_PAGE_ACK2 = 12;
   localparam int PXS_PAGE_TOG = 11;
   localparam int PXS_PRE_100 = 7;
   localparam int PXS_PRE_10 = 6;
   localparam int PXS_EN_LSB = 8;
   localparam int PXS_NUM_EV = 8;
   // ------------------------------------------------------------
   // reset values and constants
   // ------------------------------------------------------------
   localparam logic [2:0] PXS_STRAP_RESTORE = 3'h4;
   localparam logic [5:0] PXS_PRE_LOW_RST = 6'h01;
   localparam logic [15:0] PXS_CNT_RST = 16'h0000;
   localparam logic [15:0] PXS_CNT_MAX = 16'hFFFF;
   localparam logic [7:0] PXS_EN_RST = 8'h00;
   localparam logic [7:0] PXS_FLAG_RST = 8'h00;
   localparam logic [3:0] PXS_SKIP_100 = 4'h1;
   localparam logic [3:0] PXS_SKIP_10 = 4'h7;
   localparam logic [7:0] PXS_SFD = 8'hD5;
endpackage
`default_nettype wire

// ===== hw/pxs_event_flags.sv
`default_nettype none
module pxs_event_flags
   import pxs_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [7:0] events,
   input wire logic clear,
   input wire logic [7:0] enables,
   input wire logic polarity,
   output logic [7:0] flags,
   output logic irq_out
);
   logic [7:0] flags_reg;
   logic [7:0] flags_next;
   logic irq_reg;
   logic irq_next;

   always_comb
   begin
      // set beats clear so nothing is lost
      flags_next = (clear ? PXS_FLAG_RST : flags_reg) | events;
      irq_next = polarity ? |(flags_next & enables) :
         ~|(flags_next & enables);
   end

   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         flags_reg <= PXS_FLAG_RST;
         // inactive level for whichever polarity is chosen
         irq_reg <= ~polarity;
      end
      else if (ce)
      begin
         flags_reg <= flags_next;
         irq_reg <= irq_next;
      end
   end

   assign flags = flags_reg;
   assign irq_out = irq_reg;

   a_event_kept: assert property (@(posedge core_clk) disable iff (!rstn)
      ce && events[0] |=> flags_reg[0])
      else $error("event lost");
   a_irq_level: assert property (@(posedge core_clk) disable iff (!rstn)
      $past(ce) |-> irq_reg == (polarity == $past(polarity) ?
      (|(flags_reg & $past(enables)) == polarity) : irq_reg))
      else $error("irq level wrong");
endmodule
`default_nettype wire

// ===== hw/pxs_preamble_trim.sv
`default_nettype none
module pxs_preamble_trim
   import pxs_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic speed_100,
   input wire logic restore_100,
   input wire logic restore_10,
   input wire logic rx_dv_in,
   input wire logic [7:0] rx_byte_in,
   output logic rx_dv_out,
   output logic [7:0] rx_byte_out
);
   logic [3:0] pos_reg;
   logic [3:0] pos_next;
   logic dv_reg;
   logic dv_next;
   logic [7:0] byte_reg;
   logic [7:0] byte_next;
   logic drop;

   always_comb
   begin
      drop = 1'b0;
      if (speed_100 && !restore_100 && pos_reg < PXS_SKIP_100)
         drop = 1'b1;
      if (!speed_100 && !restore_10 && pos_reg < PXS_SKIP_10 &&
         rx_byte_in != PXS_SFD)
         drop = 1'b1;
      pos_next = pos_reg;
      if (!rx_dv_in)
         pos_next = 4'h0;
      else if (pos_reg != 4'hF)
         pos_next = pos_reg + 4'h1;
      dv_next = rx_dv_in && !drop;
      byte_next = rx_byte_in;
   end

   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         pos_reg <= 4'h0;
         dv_reg <= 1'b0;
         byte_reg <= 8'h00;
      end
      else if (ce)
      begin
         pos_reg <= pos_next;
         dv_reg <= dv_next;
         byte_reg <= byte_next;
      end
   end

   assign rx_dv_out = dv_reg;
   assign rx_byte_out = byte_reg;

   a_first_drop: assert property (@(posedge core_clk) disable iff (!rstn)
      ce && speed_100 && !restore_100 && rx_dv_in && pos_reg == 4'h0
      |=> !rx_dv_out)
      else $error("100M byte not dropped");
   a_keep_all: assert property (@(posedge core_clk) disable iff (!rstn)
      ce && !speed_100 && restore_10 && rx_dv_in |=> rx_dv_out)
      else $error("10M preamble not kept");
endmodule
`default_nettype wire

// ===== hw/pxs_regs.sv
`default_nettype none
module pxs_regs
   import pxs_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [4:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   input wire logic [2:0] config_strap,
   input wire logic [15:0] partner_page_word,
   input wire logic irq_polarity,
   input wire logic speed_100,
   input wire logic ev_jabber,
   input wire logic ev_receive_error,
   input wire logic ev_page_received,
   input wire logic ev_parallel_fault,
   input wire logic ev_partner_ack,
   input wire logic link_status,
   input wire logic ev_remote_fault,
   input wire logic symbol_error_frame,
   input wire logic rx_dv_in,
   input wire logic [7:0] rx_byte_in,
   output logic rx_dv_out,
   output logic [7:0] rx_byte_out,
   output logic irq_out
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic restore_100_reg;
   logic restore_100_next;
   logic restore_10_reg;
   logic restore_10_next;
   logic [7:0] en_reg;
   logic [7:0] en_next;
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic link_reg;
   logic link_next;
   logic strap_done_reg;
   logic strap_done_next;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   logic [7:0] flags;
   logic [7:0] events;
   logic irq_clear;

   function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
      hit = (a == r);
   endfunction

   // ------------------------------------------------------------
   // events
   // ------------------------------------------------------------
   always_comb
   begin
      events = {ev_jabber,
         ev_receive_error,
         ev_page_received,
         ev_parallel_fault,
         ev_partner_ack,
         link_reg & ~link_status,
         ev_remote_fault,
         ~link_reg & link_status};
      irq_clear = reg_rd && hit(reg_addr, PXS_ADDR_IRQ);
   end

   // ------------------------------------------------------------
   // register next values
   // ------------------------------------------------------------
   always_comb
   begin
      restore_100_next = restore_100_reg;
      restore_10_next = restore_10_reg;
      en_next = en_reg;
      cnt_next = cnt_reg;
      link_next = link_status;
      strap_done_next = 1'b1;
      // strap caught on first clocked cycle after reset release
      if (!strap_done_reg)
         restore_100_next = (config_strap == PXS_STRAP_RESTORE);
      if (reg_wr && hit(reg_addr, PXS_ADDR_PRE))
      begin
         restore_100_next = reg_wdata[PXS_PRE_100];
         restore_10_next = reg_wdata[PXS_PRE_10];
      end
      if (reg_wr && hit(reg_addr, PXS_ADDR_IRQ))
         en_next = reg_wdata[15:PXS_EN_LSB];
      // a frame arriving on the clearing read counts as one
      if (reg_rd && hit(reg_addr, PXS_ADDR_CNT))
         cnt_next = symbol_error_frame ? 16'h0001 : PXS_CNT_RST;
      else if (symbol_error_frame && cnt_reg != PXS_CNT_MAX)
         cnt_next = cnt_reg + 16'h0001;
      rdata_next = 16'h0000;
      unique case (reg_addr)
         PXS_ADDR_PAGE:
            rdata_next = {partner_page_word[PXS_PAGE_NP],
               partner_page_word[PXS_PAGE_ACK],
               partner_page_word[PXS_PAGE_MP],
               partner_page_word[PXS_PAGE_ACK2],
               ~partner_page_word[PXS_PAGE_TOG],
               partner_page_word[10:0]};
         PXS_ADDR_PRE:
            rdata_next = {8'h00, restore_100_reg, restore_10_reg,
               PXS_PRE_LOW_RST};
         PXS_ADDR_CNT:
            rdata_next = cnt_reg;
         PXS_ADDR_IRQ:
            rdata_next = {en_reg, flags};
         default:
            rdata_next = 16'h0000;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         restore_100_reg <= 1'b0;
         restore_10_reg <= 1'b0;
         en_reg <= PXS_EN_RST;
         cnt_reg <= PXS_CNT_RST;
         link_reg <= 1'b0;
         strap_done_reg <= 1'b0;
         rdata_reg <= 16'h0000;
      end
      else if (ce)
      begin
         restore_100_reg <= restore_100_next;
         restore_10_reg <= restore_10_next;
         en_reg <= en_next;
         cnt_reg <= cnt_next;
         link_reg <= link_next;
         strap_done_reg <= strap_done_next;
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;

   // ------------------------------------------------------------
   // submodules
   // ------------------------------------------------------------
   pxs_event_flags u_flags (
      .core_clk(core_clk),
      .rstn(rstn),
      .ce(ce),
      .events(events),
      .clear(irq_clear),
      .enables(en_reg),
      .polarity(irq_polarity),
      .flags(flags),
      .irq_out(irq_out)
   );

   pxs_preamble_trim u_trim (
      .core_clk(core_clk),
      .rstn(rstn),
      .ce(ce),
      .speed_100(speed_100),
      .restore_100(restore_100_reg),
      .restore_10(restore_10_reg),
      .rx_dv_in(rx_dv_in),
      .rx_byte_in(rx_byte_in),
      .rx_dv_out(rx_dv_out),
      .rx_byte_out(rx_byte_out)
   );

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_cnt_read;
      ce && reg_rd && hit(reg_addr, PXS_ADDR_CNT) && !symbol_error_frame;
   endsequence

   a_count_clear: assert property (@(posedge core_clk) disable iff (!rstn)
      s_cnt_read |=> cnt_reg == PXS_CNT_RST)
      else $error("counter not cleared by read");
   a_count_sat: assert property (@(posedge core_clk) disable iff (!rstn)
      ce && cnt_reg == PXS_CNT_MAX && !(reg_rd && hit(reg_addr, PXS_ADDR_CNT))
      |=> cnt_reg == PXS_CNT_MAX)
      else $error("counter wrapped");
   a_toggle_inv: assert property (@(posedge core_clk) disable iff (!rstn)
      ce && hit(reg_addr, PXS_ADDR_PAGE) |=>
      reg_rdata[PXS_PAGE_TOG] != $past(partner_page_word[PXS_PAGE_TOG]))
      else $error("toggle not inverted");
   a_page_copy: assert property (@(posedge core_clk) disable iff (!rstn)
      ce && hit(reg_addr, PXS_ADDR_PAGE) |=>
      reg_rdata[15:12] == $past(partner_page_word[15:12]))
      else $error("page bits not copied");
   a_link_down: assert property (@(posedge core_clk) disable iff (!rstn)
      ce && link_reg && !link_status |=> flags[2])
      else $error("link down not flagged");
   a_link_up: assert property (@(posedge core_clk) disable iff (!rstn)
      ce && !link_reg && link_status |=> flags[0])
      else $error("link up not flagged");
   a_en_write: assert property (@(posedge core_clk) disable iff (!rstn)
      ce && reg_wr && hit(reg_addr, PXS_ADDR_IRQ) |=>
      en_reg == $past(reg_wdata[15:8]))
      else $error("enable write lost");
   a_flag_clear: assert property (@(posedge core_clk) disable iff (!rstn)
      ce && irq_clear && events == 8'h00 |=> flags == 8'h00)
      else $error("flags not cleared on read");
   a_strap_rst: assert property (@(posedge core_clk) disable iff (!rstn)
      ce && !strap_done_reg && !reg_wr |=>
      restore_100_reg == ($past(config_strap) == PXS_STRAP_RESTORE))
      else $error("strap default wrong");
endmodule
`default_nettype wire

// ===== dv/pxs_mgmt_model.sv
`default_nettype none
module pxs_mgmt_model
   import pxs_pkg::*;
(
   input wire logic core_clk,
   output logic [4:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      reg_addr = 5'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 16'h0000;
   end

   // ------------------------------------------------------------
   // accesses: caller stands at a falling edge
   // ------------------------------------------------------------
   // idle cycle after each access so a strobe never rises again
   // in the time step where it fell
   task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
      reg_wdata = ~d;
      @(negedge core_clk);
   endtask

   task automatic read_reg(input logic [4:0] a, output logic [15:0] d);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge core_clk);
      reg_rd = 1'b0;
      d = reg_rdata;
      @(negedge core_clk);
   endtask
endmodule
`default_nettype wire

// ===== dv/tb_pxs_regs.sv
`default_nettype none
module tb_pxs_regs
   import pxs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic [2:0] config_strap = 3'h4;
   logic [15:0] page_word = 16'h0000;
   logic irq_polarity = 1'b0;
   logic speed_100 = 1'b1;
   logic [7:0] ev = 8'h00;
   logic link_status = 1'b0;
   logic symbol_error_frame = 1'b0;
   logic rx_dv_in = 1'b0;
   logic [7:0] rx_byte_in = 8'h00;
   logic [4:0] reg_addr;
   logic reg_wr;
   logic reg_rd;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic rx_dv_out;
   logic irq_out;
   logic [7:0] rx_byte_out;
   logic [7:0] q[$];
   int num_errors = 0;
   int total_checks = 0;

   always #20 core_clk = ~core_clk;

   pxs_regs pxs_regs_i (.core_clk(core_clk), .rstn(rstn), .ce(ce),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .config_strap(config_strap), .partner_page_word(page_word),
      .irq_polarity(irq_polarity), .speed_100(speed_100),
      .ev_jabber(ev[7]), .ev_receive_error(ev[6]),
      .ev_page_received(ev[5]), .ev_parallel_fault(ev[4]),
      .ev_partner_ack(ev[3]), .link_status(link_status),
      .ev_remote_fault(ev[1]), .symbol_error_frame(symbol_error_frame),
      .rx_dv_in(rx_dv_in), .rx_byte_in(rx_byte_in),
      .rx_dv_out(rx_dv_out), .rx_byte_out(rx_byte_out),
      .irq_out(irq_out));

   pxs_mgmt_model pxs_mgmt_model_i (.core_clk(core_clk),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] got,
      input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      pxs_mgmt_model_i.write_reg(a, d);
   endtask

   task automatic rdc(input string n, input logic [4:0] a,
      input logic [15:0] e);
      logic [15:0] v;
      pxs_mgmt_model_i.read_reg(a, v);
      check(n, v, e);
   endtask

   task automatic do_reset(input logic [2:0] s);
      @(negedge core_clk);
      rstn = 1'b0;
      config_strap = s;
      repeat (8) @(negedge core_clk);
      rstn = 1'b1;
      @(negedge core_clk);
   endtask

   // seven preamble bytes, delimiter, two data bytes
   task automatic frame();
      for (int i = 0; i < 10; i++)
      begin
         rx_dv_in = 1'b1;
         rx_byte_in = (i < 7) ? 8'h55 : ((i == 7) ? PXS_SFD : 8'(i));
         @(negedge core_clk);
      end
      rx_dv_in = 1'b0;
      rx_byte_in = 8'hAA;
      repeat (3) @(negedge core_clk);
   endtask

   always @(negedge core_clk)
      if (rx_dv_out === 1'b1)
         q.push_back(rx_byte_out);

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial
   begin
      do_reset(3'h4);
      rdc("pre", PXS_ADDR_PRE, 16'h0081);
      rdc("irq reg", PXS_ADDR_IRQ, 16'h0000);
      rdc("count", PXS_ADDR_CNT, 16'h0000);
      check("irq idle", {15'h0, irq_out}, 16'h0001);
      do_reset(3'h5);
      rdc("pre", PXS_ADDR_PRE, 16'h0001);
      for (int i = 0; i < 2; i++)
      begin
         page_word = (i == 1) ? 16'h57FA : 16'hA805;
         wr(PXS_ADDR_PAGE, 16'hFFFF);
         rdc("page", PXS_ADDR_PAGE, page_word ^ 16'h0800);
      end
      wr(5'h1C, 16'hFFFF);
      rdc("unmapped", 5'h1C, 16'h0000);
      wr(PXS_ADDR_IRQ, 16'hFFFF);
      rdc("enables", PXS_ADDR_IRQ, 16'hFF00);
      wr(PXS_ADDR_IRQ, 16'h0000);
      // every event alone with enables off: flag only, no interrupt
      for (int i = 0; i < 8; i++)
      begin
         if (i == 0 || i == 2)
            link_status = (i == 0);
         else
            ev[i] = 1'b1;
         @(negedge core_clk);
         ev = 8'h00;
         check("irq masked", {15'h0, irq_out}, 16'h0001);
         rdc("f", PXS_ADDR_IRQ, 16'h1 << i);
         rdc("c", PXS_ADDR_IRQ, 16'h0000);
      end
      // event only in the clearing cycle, so a lost set shows up
      ev[7] = 1'b1;
      fork
         rdc("clear race", PXS_ADDR_IRQ, 16'h0000);
         begin
            @(negedge core_clk);
            ev[7] = 1'b0;
         end
      join
      rdc("kept flag", PXS_ADDR_IRQ, 16'h0080);
      wr(PXS_ADDR_IRQ, 16'h8000);
      check("irq off", {15'h0, irq_out}, 16'h0001);
      // clock enable low: the write must not land
      ce = 1'b0;
      wr(PXS_ADDR_IRQ, 16'h0000);
      ce = 1'b1;
      rdc("ce hold", PXS_ADDR_IRQ, 16'h8000);
      for (int p = 0; p < 2; p++)
      begin
         irq_polarity = p[0];
         @(negedge core_clk);
         check("irq idle", {15'h0, irq_out}, {15'h0, ~p[0]});
         ev[7] = 1'b1;
         @(negedge core_clk);
         ev[7] = 1'b0;
         check("irq on", {15'h0, irq_out}, {15'h0, p[0]});
         rdc("irq read", PXS_ADDR_IRQ, 16'h8080);
         check("irq drop", {15'h0, irq_out}, {15'h0, ~p[0]});
      end
      // 0: 10M strip, 1: 10M keep, 2: 100M drop one, 3: 100M keep
      for (int m = 0; m < 4; m++)
      begin
         speed_100 = m[1];
         wr(PXS_ADDR_PRE, {8'h00, m[0], m[0], 6'h00});
         rdc("pre", PXS_ADDR_PRE, {8'h00, m[0], m[0], 6'h01});
         q.delete();
         frame();
         check("len", 16'(q.size()),
            m[0] ? 16'h000A : (m[1] ? 16'h0009 : 16'h0003));
         check("first", {8'h00, q[0]}, (m == 0) ? 16'h00D5 : 16'h0055);
      end
      symbol_error_frame = 1'b1;
      repeat (5) @(negedge core_clk);
      symbol_error_frame = 1'b0;
      wr(PXS_ADDR_CNT, 16'h1234);
      rdc("cnt", PXS_ADDR_CNT, 16'h0005);
      rdc("cnt", PXS_ADDR_CNT, 16'h0000);
      symbol_error_frame = 1'b1;
      repeat (65537) @(negedge core_clk);
      symbol_error_frame = 1'b0;
      rdc("cnt sat", PXS_ADDR_CNT, 16'hFFFF);
      // frames during read and idle cycle both count after the clear
      symbol_error_frame = 1'b1;
      rdc("cnt", PXS_ADDR_CNT, 16'h0000);
      symbol_error_frame = 1'b0;
      rdc("cnt", PXS_ADDR_CNT, 16'h0002);
      summarize();
   end

   // run is about 66k cycles
   initial
   begin
      #4000000;
      num_errors++;
      summarize();
   end
endmodule
`default_nettype wire
